/* File: hw/srs_seq.sv */
// Halt-recovery and debugger-initiated reset sequencer
//
// Functional notes
// - Debugger reset request resets everything except the debug unit, like power-on; the code keeps the halt-recovery and watchdog time-out flags.
// - Debugger reset request bit clears itself while its system reset runs.
// - Power-on flag is set once a debugger-requested reset completes.
// - Halted state is entered only on the core's halt instruction.
// - Halt recovery holds reset 66 oscillator cycles, then 16 system clocks.
// - Halt recovery alters only watchdog control flags; other state is kept.
// - After reset the core fetches its vector from bytes 0002H and 0003H.
// - Every halt recovery sets the halt-recovery flag to 1.
// - Watchdog time-out while halted, reset-configured, starts halt recovery.
// - Interrupt-configured watchdog time-out recovers, then requests the watchdog interrupt.
// - Transition on an enabled recovery GPIO pin starts halt recovery.
// - Watchdog time-out while halted sets watchdog time-out and halt-recovery flags.
`timescale 1ns/1ps
`default_nettype none
module srs_seq (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic dbg_rst_req,
  input wire logic halt_exec,
  input wire logic wdt_osc_tick,
  input wire logic wdt_timeout,
  input wire logic wdt_cfg_reset,
  input wire logic [srs_pkg::GPIO_W-1:0] gpio_in,
  input wire logic [srs_pkg::GPIO_W-1:0] gpio_recov_en,
  input wire logic wdctl_flag_clr,
  output logic dbg_rst_bit,
  output logic sys_rst_n,
  output logic core_rst_n,
  output logic halted,
  output logic por_flag,
  output logic halt_recov_flag,
  output logic watchdog_timeout_flag,
  output logic wdt_irq_req,
  output logic vec_fetch,
  output logic [15:0] vec_ptr
);
  import srs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    srs_state_t state;
    logic kind_dbg;
    logic src_wdt_int;
    logic [GPIO_W-1:0] gpio_prev;
    logic dbg_rst_bit;
    logic sys_rst_n;
    logic core_rst_n;
    logic halted;
    logic por_flag;
    logic halt_flag;
    logic wdt_flag;
    logic wdt_irq;
    logic vec_fetch;
    logic [15:0] vec_ptr;
  } srs_st_t;

  srs_st_t st_ff;
  srs_st_t nxt_st;

  logic cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic cnt_dec;
  logic cnt_zero;
  logic [GPIO_W-1:0] gpio_edge;
  logic set_halt;
  logic set_por;
  logic set_wdt;

  // ----------------------------------------------------------------
  // Recovery source detection
  // ----------------------------------------------------------------
  // Inputs are synchronous, so one previous sample suffices to see an edge
  for (genvar i = 0; i < GPIO_W; i++) begin : g_gpio
    assign gpio_edge[i] = (gpio_in[i] ^ st_ff.gpio_prev[i]) & gpio_recov_en[i];
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.gpio_prev = gpio_in;
    nxt_st.vec_fetch = 1'b0;
    nxt_st.wdt_irq = 1'b0;
    cnt_load = 1'b0;
    cnt_val = OSC_HOLD_CYC;
    cnt_dec = 1'b0;
    set_halt = 1'b0;
    set_por = 1'b0;
    set_wdt = 1'b0;
    if (dbg_rst_req) begin
      nxt_st.dbg_rst_bit = 1'b1;
    end
    case (st_ff.state)
      SRS_RUN: begin
        if (st_ff.dbg_rst_bit) begin
          nxt_st.state = SRS_OSCW;
          nxt_st.kind_dbg = 1'b1;
          nxt_st.src_wdt_int = 1'b0;
          nxt_st.sys_rst_n = 1'b0;
          nxt_st.core_rst_n = 1'b0;
          cnt_load = 1'b1;
        end else if (halt_exec) begin
          nxt_st.state = SRS_HALT;
          nxt_st.halted = 1'b1;
        end
      end
      SRS_HALT: begin
        if (st_ff.dbg_rst_bit) begin
          nxt_st.state = SRS_OSCW;
          nxt_st.kind_dbg = 1'b1;
          nxt_st.src_wdt_int = 1'b0;
          nxt_st.sys_rst_n = 1'b0;
          nxt_st.core_rst_n = 1'b0;
          nxt_st.halted = 1'b0;
          cnt_load = 1'b1;
        end else if (wdt_timeout || gpio_edge != '0) begin
          nxt_st.state = SRS_OSCW;
          nxt_st.kind_dbg = 1'b0;
          nxt_st.src_wdt_int = wdt_timeout & ~wdt_cfg_reset;
          // Only the core is restarted; register file and peripherals keep state
          nxt_st.core_rst_n = 1'b0;
          nxt_st.halted = 1'b0;
          set_wdt = wdt_timeout;
          cnt_load = 1'b1;
        end
      end
      SRS_OSCW: begin
        if (st_ff.kind_dbg) begin
          nxt_st.dbg_rst_bit = 1'b0;
        end
        cnt_dec = wdt_osc_tick;
        if (cnt_zero) begin
          nxt_st.state = SRS_CLKW;
          cnt_load = 1'b1;
          cnt_val = CLK_HOLD_CYC;
        end
      end
      SRS_CLKW: begin
        cnt_dec = 1'b1;
        if (cnt_zero) begin
          // Both resets drop on the same registered edge
          nxt_st.state = SRS_RUN;
          nxt_st.sys_rst_n = 1'b1;
          nxt_st.core_rst_n = 1'b1;
          nxt_st.vec_fetch = 1'b1;
          nxt_st.vec_ptr = VEC_ADDR_HI;
          nxt_st.wdt_irq = st_ff.src_wdt_int;
          set_por = st_ff.kind_dbg;
          set_halt = ~st_ff.kind_dbg;
        end
      end
      default: begin
        nxt_st.state = SRS_RUN;
      end
    endcase
    // A flag set in the same cycle as a software clear survives
    if (wdctl_flag_clr) begin
      nxt_st.por_flag = 1'b0;
      nxt_st.halt_flag = 1'b0;
      nxt_st.wdt_flag = 1'b0;
    end
    if (set_por) begin
      nxt_st.por_flag = 1'b1;
    end
    if (set_halt) begin
      nxt_st.halt_flag = 1'b1;
    end
    if (set_wdt) begin
      nxt_st.wdt_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff.state <= SRS_RUN;
      st_ff.kind_dbg <= 1'b0;
      st_ff.src_wdt_int <= 1'b0;
      st_ff.gpio_prev <= GPIO_RST;
      st_ff.dbg_rst_bit <= 1'b0;
      st_ff.sys_rst_n <= 1'b1;
      st_ff.core_rst_n <= 1'b1;
      st_ff.halted <= 1'b0;
      st_ff.por_flag <= 1'b1;
      st_ff.halt_flag <= 1'b0;
      st_ff.wdt_flag <= 1'b0;
      st_ff.wdt_irq <= 1'b0;
      st_ff.vec_fetch <= 1'b0;
      st_ff.vec_ptr <= VEC_PTR_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Hold counter
  // ----------------------------------------------------------------
  srs_hold_cnt u_cnt (
    .mclk(mclk),
    .rstn(rstn),
    .load(cnt_load),
    .load_val(cnt_val),
    .dec(cnt_dec),
    .zero(cnt_zero)
  );

  assign dbg_rst_bit = st_ff.dbg_rst_bit;
  assign sys_rst_n = st_ff.sys_rst_n;
  assign core_rst_n = st_ff.core_rst_n;
  assign halted = st_ff.halted;
  assign por_flag = st_ff.por_flag;
  assign halt_recov_flag = st_ff.halt_flag;
  assign watchdog_timeout_flag = st_ff.wdt_flag;
  assign wdt_irq_req = st_ff.wdt_irq;
  assign vec_fetch = st_ff.vec_fetch;
  assign vec_ptr = st_ff.vec_ptr;

endmodule : srs_seq
`default_nettype wire

/* File: hw/srs_pkg.sv */
// Constants and types shared by the halt-recovery reset sequencer
package srs_pkg;

  // ----------------------------------------------------------------
  // Sequence lengths
  // ----------------------------------------------------------------
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] OSC_HOLD_CYC = 7'h42;  // 66 watchdog-oscillator cycles
  localparam logic [CNT_W-1:0] CLK_HOLD_CYC = 7'h10;  // 16 system-clock cycles

  // ----------------------------------------------------------------
  // Reset vector location and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_ADDR_HI = 16'h0002;
  localparam logic [15:0] VEC_ADDR_LO = 16'h0003;
  localparam logic [15:0] VEC_PTR_RST = 16'h0000;
  localparam int GPIO_W = 8;
  localparam logic [GPIO_W-1:0] GPIO_RST = 8'h00;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRS_RUN  = 4'h1,
    SRS_HALT = 4'h2,
    SRS_OSCW = 4'h4,
    SRS_CLKW = 4'h8
  } srs_state_t;

endpackage : srs_pkg

/* File: hw/srs_hold_cnt.sv */
// Loadable down counter used for both reset hold phases
`timescale 1ns/1ps
`default_nettype none
module srs_hold_cnt (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [srs_pkg::CNT_W-1:0] load_val,
  input wire logic dec,
  output logic zero
);
  import srs_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } srs_cnt_st_t;

  srs_cnt_st_t st_ff;
  srs_cnt_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.cnt = load_val;
    end else if (dec && st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign zero = (st_ff.cnt == '0);

endmodule : srs_hold_cnt
`default_nettype wire

/* File: bench/srs_seq_monitor.sv */
// Port-level assertions for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module srs_seq_monitor (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic dbg_rst_req,
  input wire logic halt_exec,
  input wire logic wdt_osc_tick,
  input wire logic wdt_timeout,
  input wire logic dbg_rst_bit,
  input wire logic sys_rst_n,
  input wire logic core_rst_n,
  input wire logic halted,
  input wire logic por_flag,
  input wire logic halt_recov_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic vec_fetch,
  input wire logic [15:0] vec_ptr
);
  import srs_pkg::*;
  // Two-state counters start at zero; only the clocked process below writes them
  int tk_ff;
  int lo_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Ticks and cycles seen while the core is held; cleared once it runs
  always_ff @(posedge mclk) begin
    tk_ff <= core_rst_n ? 0 : tk_ff + int'(wdt_osc_tick);
    lo_ff <= core_rst_n ? 0 : lo_ff + 1;
  end
  sequence s_wdt_wake;
    halted && wdt_timeout && !dbg_rst_bit && !dbg_rst_req;
  endsequence
  property p_halt_in; $rose(halted) |-> $past(halt_exec); endproperty
  a_halt_in: assert property (p_halt_in) else $error("halt entered unasked");
  property p_sys_low; $fell(sys_rst_n) |-> $past(dbg_rst_bit); endproperty
  a_sys_low: assert property (p_sys_low) else $error("system reset unasked");
  property p_bit_clr; dbg_rst_bit |-> ##[1:1000] !dbg_rst_bit; endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("request bit stuck");
  property p_por; $rose(sys_rst_n) |-> por_flag; endproperty
  a_por: assert property (p_por) else $error("power-on flag missing");
  property p_hold; $rose(core_rst_n) |-> tk_ff >= 66 && lo_ff >= 82; endproperty
  a_hold: assert property (p_hold) else $error("hold too short");
  property p_vec; $rose(core_rst_n) |-> vec_fetch && vec_ptr == VEC_ADDR_HI; endproperty
  a_vec: assert property (p_vec) else $error("vector fetch wrong");
  property p_hr; $rose(core_rst_n) && $past(sys_rst_n) |-> halt_recov_flag; endproperty
  a_hr: assert property (p_hr) else $error("recovery flag missing");
  property p_wake; s_wdt_wake |=> watchdog_timeout_flag && !halted && !core_rst_n; endproperty
  a_wake: assert property (p_wake) else $error("time-out wake wrong");
endmodule : srs_seq_monitor
`default_nettype wire

/* File: bench/srs_core_model.sv */
// Core-side model: loads its program counter from the vector bytes
`timescale 1ns/1ps
`default_nettype none
module srs_core_model (
  input wire logic mclk,
  input wire logic vec_fetch,
  input wire logic [15:0] vec_ptr,
  output logic [15:0] pc
);
  logic [7:0] rom [4] = '{8'h00, 8'h00, 8'h5A, 8'hC3};
  // High byte at the pointer, low byte right after it
  always @(posedge mclk) if (vec_fetch) pc <= {rom[vec_ptr[1:0]], rom[vec_ptr[1:0] + 2'h1]};
endmodule : srs_core_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srs_pkg::*;
  logic mclk = 0, rstn = 0, wdt_osc_tick = 0, wdt_cfg_reset = 1;
  logic [3:0] pls = 4'h0;
  logic [7:0] gpio_in = 8'h00, gpio_recov_en = 8'h00;
  wire logic dbg_rst_req = pls[0];
  wire logic halt_exec = pls[1];
  wire logic wdt_timeout = pls[2];
  wire logic wdctl_flag_clr = pls[3];
  logic dbg_rst_bit, sys_rst_n, core_rst_n, halted, por_flag, halt_recov_flag;
  logic watchdog_timeout_flag, wdt_irq_req, vec_fetch, e_por, e_hr, e_wt;
  logic [15:0] vec_ptr, pc;
  logic [31:0] rs = 32'h4AEE;
  int failures = 0, n_compared = 0, cyc = 0, lo;
  srs_seq dut (.mclk, .rstn, .dbg_rst_req, .halt_exec, .wdt_osc_tick, .wdt_timeout,
    .wdt_cfg_reset, .gpio_in, .gpio_recov_en, .wdctl_flag_clr, .dbg_rst_bit, .sys_rst_n,
    .core_rst_n, .halted, .por_flag, .halt_recov_flag, .watchdog_timeout_flag, .wdt_irq_req,
    .vec_fetch, .vec_ptr);
  srs_core_model core (.mclk, .vec_fetch, .vec_ptr, .pc);
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    wdt_osc_tick <= (cyc % 3 == 0);
    if (cyc == 5000) begin
      failures++;
      close_out();
    end
  end
  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic pulse(int b);
    @(posedge mclk) pls[b] <= 1'b1;
    @(posedge mclk) pls[b] <= 1'b0;
  endtask : pulse
  // Rides out one hold and checks what the release must show
  task automatic hold(logic dbg, logic irq);
    lo = 0;
    for (int i = 0; i < 6 && core_rst_n === 1'b1; i++) @(negedge mclk);
    chk({core_rst_n, sys_rst_n}, {1'b0, !dbg});
    while (core_rst_n !== 1'b1 && lo < 1000) begin
      @(negedge mclk);
      lo++;
    end
    // A release that never comes runs into the cap and must not pass
    chk(lo >= 82 && lo < 1000, 1'b1);
    chk({vec_fetch, wdt_irq_req, dbg_rst_bit, halted, por_flag, halt_recov_flag,
      watchdog_timeout_flag}, {2'b10 | irq, 2'b00, e_por, e_hr, e_wt});
    @(negedge mclk);
    chk(pc, 16'h5AC3);
    $display("sequence done dbg=%0d irq=%0d", dbg, irq);
  endtask : hold
  task automatic close_out();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk({por_flag, halt_recov_flag, watchdog_timeout_flag, core_rst_n, halted}, 5'h12);
    pulse(3);
    pulse(0);
    {e_por, e_hr, e_wt} = 3'b100;
    hold(1'b1, 1'b0);
    for (int c = 0; c < 2; c++) begin
      @(posedge mclk) wdt_cfg_reset <= c[0] ? 1'b0 : 1'b1;
      pulse(3);
      pulse(2);
      repeat (4) @(negedge mclk);
      chk(core_rst_n, 1'b1);
      pulse(1);
      @(negedge mclk);
      chk(halted, 1'b1);
      pulse(2);
      {e_por, e_hr, e_wt} = 3'b011;
      hold(1'b0, c[0]);
    end
    for (int g = 0; g < 3; g++) begin
      rs = xs(rs);
      @(posedge mclk) gpio_recov_en <= 8'h01 << rs[2:0];
      pulse(3);
      pulse(1);
      @(posedge mclk) gpio_in <= gpio_in ^ ~gpio_recov_en;
      repeat (4) @(negedge mclk);
      chk(halted, 1'b1);
      @(posedge mclk) gpio_in <= gpio_in ^ gpio_recov_en;
      {e_por, e_hr, e_wt} = 3'b010;
      hold(1'b0, 1'b0);
    end
    // Debugger request while halted: full system reset, recovery flag left as it was
    pulse(1);
    @(negedge mclk);
    chk(halted, 1'b1);
    pulse(0);
    {e_por, e_hr, e_wt} = 3'b110;
    hold(1'b1, 1'b0);
    close_out();
  end
endmodule : testbench
bind srs_seq srs_seq_monitor mon (.mclk, .rstn, .dbg_rst_req, .halt_exec, .wdt_osc_tick,
  .wdt_timeout, .dbg_rst_bit, .sys_rst_n, .core_rst_n, .halted, .por_flag, .halt_recov_flag,
  .watchdog_timeout_flag, .vec_fetch, .vec_ptr);
`default_nettype wire
